/* hdl/pwmfc_defines.svh */
// Register offsets, field positions, reset values and timing counts
// for the PWM fault/config slice. Included by every design file except the package.
`ifndef PWMFC_DEFINES_SVH
`define PWMFC_DEFINES_SVH
`define PWMFC_OFS_PROTECT 4'h0
`define PWMFC_OFS_POLARITY 4'h1
`define PWMFC_OFS_MASK 4'h2
`define PWMFC_OFS_CFG3 4'h3
`define PWMFC_OFS_FCTL 4'h4
`define PWMFC_OFS_FPIN 4'h5
`define PWMFC_OFS_FSTA 4'h6
`define PWMFC_OFS_QUALIFY_SAMPLE_COUNT 4'h7
`define PWMFC_OFS_DMAP0 4'h8
`define PWMFC_OFS_DMAP1 4'h9
`define PWMFC_OFS_DMAP2 4'hA
`define PWMFC_BIT_WP 7
`define PWMFC_BIT_ACCEL 7
`define PWMFC_BIT_WAIT 7
`define PWMFC_BIT_FRZ 6
`define PWMFC_RST_BYTE 8'h00
`define PWMFC_CFG3_WMASK 8'hDF
`define PWMFC_QUAL_FIRST 3'h2
`define PWMFC_QUAL_PERIOD 3'h4
`define PWMFC_QCNT_00 4'h1
`define PWMFC_QCNT_01 4'h5
`define PWMFC_QCNT_10 4'hA
`define PWMFC_QCNT_11 4'hF
`endif

/* hdl/pwmfc_pkg.sv */
// Types shared by the PWM fault/config slice.
// Assumes the defines header is compiled alongside.
package pwmfc_pkg;
   typedef enum logic [1:0] {
      PWMFC_Q_IDLE = 2'b00,
      PWMFC_Q_FIRST = 2'b01,
      PWMFC_Q_RUN = 2'b10
   } pwmfc_qstate_t;
   typedef enum logic [1:0] {
      PWMFC_VL_INDEP = 2'b00,
      PWMFC_VL_ALL = 2'b01,
      PWMFC_VL_LOW4 = 2'b10,
      PWMFC_VL_RSVD = 2'b11
   } pwmfc_value_load_mode_t;
endpackage

/* hdl/pwmfc_qualifier.sv */
// Fault input qualifier: counts consecutive high samples of one fault input.
// Assumes the fault input is synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "pwmfc_defines.svh"
module pwmfc_qualifier
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic faultPin,
   input wire logic enable,
   input wire logic [3:0] needCount,
   output logic qualified,
   output logic detect
);
   import pwmfc_pkg::*;
   pwmfc_qstate_t state;
   logic [2:0] timer;
   logic [3:0] count;
   logic sampleNow;

   // First sample after two cycles, later ones every four
   assign sampleNow = (state == PWMFC_Q_FIRST) ? (timer == `PWMFC_QUAL_FIRST)
                      : (timer == `PWMFC_QUAL_PERIOD);

   // Sampling sequencer
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= PWMFC_Q_IDLE;
         timer <= 3'h0;
         count <= 4'h0;
      end
      else
      begin
         case (state)
            PWMFC_Q_IDLE:
            begin
               count <= 4'h0;
               timer <= 3'h1;
               if (faultPin && enable)
                  state <= PWMFC_Q_FIRST;
            end
            PWMFC_Q_FIRST, PWMFC_Q_RUN:
            begin
               if (!enable)
                  state <= PWMFC_Q_IDLE;
               else if (sampleNow)
               begin
                  timer <= 3'h1;
                  if (!faultPin)
                     state <= PWMFC_Q_IDLE; // Consecutive run broken
                  else
                  begin
                     state <= PWMFC_Q_RUN;
                     if (count != 4'hF)
                        count <= count + 4'h1;
                  end
               end
               else
                  timer <= timer + 3'h1;
            end
            default:
               state <= PWMFC_Q_IDLE;
         endcase
      end
   end

   // Qualified level and its rising-edge pulse
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         qualified <= 1'b0;
         detect <= 1'b0;
      end
      else
      begin
         qualified <= (state != PWMFC_Q_IDLE) && (count >= needCount) && enable;
         detect <= !qualified && (state != PWMFC_Q_IDLE) && (count >= needCount) && enable;
      end
   end

   property p_first_sample;
      @(posedge clk) disable iff (!reset_n)
      (state == PWMFC_Q_IDLE && faultPin && enable) ##1 enable |=> (timer == 3'h2);
   endproperty
   a_first_sample: assert property (p_first_sample)
      else $error("first sample not due two cycles after fault");

   property p_one_sample;
      @(posedge clk) disable iff (!reset_n)
      (needCount == 4'h1 && state == PWMFC_Q_IDLE && enable)
         ##1 (faultPin && enable)[*3] ##1 (enable && needCount == 4'h1) |=> qualified;
   endproperty
   a_one_sample: assert property (p_one_sample)
      else $error("single-sample fault not qualified in time");
endmodule // pwmfc_qualifier
`default_nettype wire

/* hdl/pwmfc_top.sv */
// Configuration and fault-protection slice of a six-channel PWM module.
// Assumes waveforms, fault inputs and mode strobes are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "pwmfc_defines.svh"
module pwmfc_top
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic waitMode,
   input wire logic freezeMode,
   input wire logic [5:0] pwmIn,
   input wire logic [3:0] faultIn,
   input wire logic valueWrStrobe,
   input wire logic [2:0] valueWrIndex,
   output logic [5:0] valueWrSelect,
   output logic [5:0] pwmOut,
   output logic faultIrq
);
   import pwmfc_pkg::*;

   logic writeProtect, accelWriteEnable, stopInWait, stopInFreeze, stopNow;
   logic [2:0] independent, pairExchange;
   logic [5:0] invert, outputMask, swapped, shaped, faultDisable;
   pwmfc_value_load_mode_t valueLoadMode;
   logic [3:0] faultClearMode, faultIrqEnable, faultInputEnable, faultFlag;
   logic [3:0] qualified, detect, needCount, faultActive, flagClear, next_faultFlag;
   logic [1:0] qualifySampleCount;
   logic [23:0] disableMap;
   logic [7:0] readMux;

   // Write strobes per register
   logic wrProtect, wrPolarity, wrMask, wrCfg3, wrFctl, wrFpin, wrFsta, wrQsmp;
   assign wrProtect = regWrite && (regAddr == `PWMFC_OFS_PROTECT);
   assign wrPolarity = regWrite && (regAddr == `PWMFC_OFS_POLARITY);
   assign wrMask = regWrite && (regAddr == `PWMFC_OFS_MASK);
   assign wrCfg3 = regWrite && (regAddr == `PWMFC_OFS_CFG3);
   assign wrFctl = regWrite && (regAddr == `PWMFC_OFS_FCTL);
   assign wrFpin = regWrite && (regAddr == `PWMFC_OFS_FPIN);
   assign wrFsta = regWrite && (regAddr == `PWMFC_OFS_FSTA);
   assign wrQsmp = regWrite && (regAddr == `PWMFC_OFS_QUALIFY_SAMPLE_COUNT);

   // Protect register: write protect only sets, cleared by reset alone
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         writeProtect <= 1'b0;
         independent <= 3'h0;
      end
      else if (wrProtect && !writeProtect)
      begin
         writeProtect <= regWrData[`PWMFC_BIT_WP];
         independent <= regWrData[2:0];
      end
   end

   // Accel enable and polarity, frozen once protected
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         accelWriteEnable <= 1'b0;
         invert <= 6'h00;
      end
      else if (wrPolarity && !writeProtect)
      begin
         accelWriteEnable <= regWrData[`PWMFC_BIT_ACCEL];
         invert <= regWrData[5:0];
      end
   end

   // Channel mask, writable any time
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         outputMask <= 6'h00;
      else if (wrMask)
         outputMask <= regWrData[5:0];
   end

   // Low-power bits free; load mode and swaps gated by accel enable
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stopInWait <= 1'b0;
         stopInFreeze <= 1'b0;
         valueLoadMode <= PWMFC_VL_INDEP;
         pairExchange <= 3'h0;
      end
      else if (wrCfg3)
      begin
         stopInWait <= regWrData[`PWMFC_BIT_WAIT];
         stopInFreeze <= regWrData[`PWMFC_BIT_FRZ];
         if (accelWriteEnable)
         begin
            valueLoadMode <= pwmfc_value_load_mode_t'(regWrData[4:3]);
            pairExchange <= regWrData[2:0];
         end
      end
   end

   // Fault control: odd bits clear mode, even bits irq enable
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         faultClearMode <= 4'h0;
         faultIrqEnable <= 4'h0;
      end
      else if (wrFctl)
      begin
         faultClearMode <= {regWrData[7], regWrData[5], regWrData[3], regWrData[1]};
         faultIrqEnable <= {regWrData[6], regWrData[4], regWrData[2], regWrData[0]};
      end
   end

   // Fault input enable, locked by write protect
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         faultInputEnable <= 4'h0;
      else if (wrFpin && !writeProtect)
         faultInputEnable <= regWrData[3:0];
   end

   // Sample count and disable maps, locked by write protect
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         qualifySampleCount <= 2'h0;
         disableMap <= 24'h000000;
      end
      else if (regWrite && !writeProtect)
      begin
         if (wrQsmp)
            qualifySampleCount <= regWrData[1:0];
         if (regAddr == `PWMFC_OFS_DMAP0)
            disableMap[7:0] <= regWrData;
         if (regAddr == `PWMFC_OFS_DMAP1)
            disableMap[15:8] <= regWrData;
         if (regAddr == `PWMFC_OFS_DMAP2)
            disableMap[23:16] <= regWrData;
      end
   end

   // Sample count code to required run length
   assign needCount = (qualifySampleCount == 2'b00) ? `PWMFC_QCNT_00
      : (qualifySampleCount == 2'b01) ? `PWMFC_QCNT_01
      : (qualifySampleCount == 2'b10) ? `PWMFC_QCNT_10 : `PWMFC_QCNT_11;

   // One qualifier per fault input; runs whether or not PWM is active
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_qual
         pwmfc_qualifier u_qual (.clk(clk), .reset_n(reset_n), .faultPin(faultIn[gi]),
            .enable(faultInputEnable[gi]),
            .needCount(needCount), .qualified(qualified[gi]), .detect(detect[gi]));
      end
   endgenerate

   // Flags: detection beats a same-cycle clear
   assign flagClear = wrFsta ? {regWrData[6], regWrData[4], regWrData[2], regWrData[0]} : 4'h0;
   assign next_faultFlag = (faultFlag & ~flagClear) | detect;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         faultFlag <= 4'h0;
      else
         faultFlag <= next_faultFlag;
   end

   // Irq follows flags, so a clear withdraws it
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         faultIrq <= 1'b0;
      else
         faultIrq <= |(next_faultFlag & faultIrqEnable);
   end

   // Manual mode holds off until flag cleared; auto follows qualified level.
   // Raw input path disables at once, ahead of qualification.
   assign faultActive = faultInputEnable
      & ((faultClearMode & qualified) | (~faultClearMode & faultFlag) | faultIn);

   // Per-output disable from its four map bits
   generate
      for (gi = 0; gi < 6; gi = gi + 1)
      begin : g_dis
         assign faultDisable[gi] = |(disableMap[4*gi +: 4] & faultActive);
      end
   endgenerate

   // Swap pairs only in complementary mode
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_swap
         logic doSwap;
         assign doSwap = pairExchange[gi] && !independent[gi];
         assign swapped[2*gi] = doSwap ? pwmIn[2*gi+1] : pwmIn[2*gi];
         assign swapped[2*gi+1] = doSwap ? pwmIn[2*gi] : pwmIn[2*gi+1];
      end
   endgenerate

   // Mask before inversion: inverted masked channels go high by design
   assign shaped = (swapped & ~outputMask) ^ invert;
   assign stopNow = (stopInWait && waitMode) || (stopInFreeze && freezeMode);

   // Output stage; registered so outputs lag one cycle
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pwmOut <= 6'h00;
      else if (stopNow)
         pwmOut <= 6'h00;
      else
         pwmOut <= shaped & ~faultDisable;
   end

   // Value register write fan-out
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         valueWrSelect <= 6'h00;
      else if (!valueWrStrobe || valueWrIndex > 3'h5)
         valueWrSelect <= 6'h00; // No strobe, or no such register
      else if (valueWrIndex == 3'h0 && valueLoadMode == PWMFC_VL_ALL)
         valueWrSelect <= 6'h3F;
      else if (valueWrIndex == 3'h0 && valueLoadMode == PWMFC_VL_LOW4)
         valueWrSelect <= 6'h0F;
      else
         valueWrSelect <= 6'h01 << valueWrIndex;
   end

   // Read mux; reserved and unmapped read zero
   always_comb
   begin
      case (regAddr)
         `PWMFC_OFS_PROTECT: readMux = {writeProtect, 4'h0, independent};
         `PWMFC_OFS_POLARITY: readMux = {accelWriteEnable, 1'b0, invert};
         `PWMFC_OFS_MASK: readMux = {2'h0, outputMask};
         `PWMFC_OFS_CFG3: readMux = {stopInWait, stopInFreeze, 1'b0, valueLoadMode, pairExchange};
         `PWMFC_OFS_FCTL: readMux = {faultClearMode[3], faultIrqEnable[3],
                                     faultClearMode[2], faultIrqEnable[2],
                                     faultClearMode[1], faultIrqEnable[1],
                                     faultClearMode[0], faultIrqEnable[0]};
         `PWMFC_OFS_FPIN: readMux = {4'h0, faultInputEnable};
         `PWMFC_OFS_FSTA: readMux = {1'b0, faultFlag[3], 1'b0, faultFlag[2],
                                     1'b0, faultFlag[1], 1'b0, faultFlag[0]};
         `PWMFC_OFS_QUALIFY_SAMPLE_COUNT: readMux = {6'h00, qualifySampleCount};
         `PWMFC_OFS_DMAP0: readMux = disableMap[7:0];
         `PWMFC_OFS_DMAP1: readMux = disableMap[15:8];
         `PWMFC_OFS_DMAP2: readMux = disableMap[23:16];
         default: readMux = `PWMFC_RST_BYTE;
      endcase
   end

   // Read data one cycle after strobe, zero otherwise
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         regRdData <= `PWMFC_RST_BYTE;
      else
         regRdData <= regRead ? readMux : `PWMFC_RST_BYTE;
   end

   sequence s_enter_wait;
      stopInWait && waitMode;
   endsequence
   property p_stop_wait;
      @(posedge clk) disable iff (!reset_n)
      s_enter_wait |=> (pwmOut == 6'h00);
   endproperty
   a_stop_wait: assert property (p_stop_wait)
      else $error("outputs active during wait stop");
   property p_stop_freeze;
      @(posedge clk) disable iff (!reset_n)
      (stopInFreeze && freezeMode) |=> (pwmOut == 6'h00);
   endproperty
   a_stop_freeze: assert property (p_stop_freeze)
      else $error("outputs active during freeze stop");
   property p_mask;
      @(posedge clk) disable iff (!reset_n)
      (outputMask == 6'h3F && invert == 6'h00) |=> (pwmOut == 6'h00);
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked channel not at zero duty");
   property p_accel_lock;
      @(posedge clk) disable iff (!reset_n)
      (wrCfg3 && !accelWriteEnable) |=> $stable(pairExchange) && $stable(valueLoadMode);
   endproperty
   a_accel_lock: assert property (p_accel_lock)
      else $error("swap or load mode changed without accel enable");
   property p_wp_lock;
      @(posedge clk) disable iff (!reset_n)
      (wrFpin && writeProtect) |=> $stable(faultInputEnable);
   endproperty
   a_wp_lock: assert property (p_wp_lock)
      else $error("fault enable changed under write protect");
   property p_flag_set;
      @(posedge clk) disable iff (!reset_n)
      detect[0] |=> faultFlag[0];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("detected fault did not set flag");
   // A clear cannot meet an enable write, so the enables seen next cycle are current
   property p_flag_clear;
      @(posedge clk) disable iff (!reset_n)
      (wrFsta && regWrData[0] && !detect[0])
         |=> !faultFlag[0] && (faultIrq == |(faultFlag & faultIrqEnable));
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("write one did not clear flag or its interrupt");
   property p_irq;
      @(posedge clk) disable iff (!reset_n)
      ##1 (faultIrq == |(faultFlag & $past(faultIrqEnable)));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt does not follow enabled flags");
   property p_vload;
      @(posedge clk) disable iff (!reset_n)
      (valueWrStrobe && valueWrIndex == 3'h0 && valueLoadMode == PWMFC_VL_LOW4)
         |=> (valueWrSelect == 6'h0F);
   endproperty
   a_vload: assert property (p_vload)
      else $error("load mode fan-out wrong");
   property p_raw_fault;
      @(posedge clk) disable iff (!reset_n)
      (faultInputEnable[0] && faultIn[0] && disableMap[0]) |=> !pwmOut[0];
   endproperty
   a_raw_fault: assert property (p_raw_fault)
      else $error("raw fault did not disable mapped output");
endmodule // pwmfc_top
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the PWM fault/config slice.
// Assumes the design files, package and defines header are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "pwmfc_defines.svh"
module tb_top;
   import pwmfc_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdData;
   logic waitMode = 1'b0;
   logic freezeMode = 1'b0;
   logic [5:0] pwmIn = 6'h00;
   logic [3:0] faultIn = 4'h0;
   logic valueWrStrobe = 1'b0;
   logic [2:0] valueWrIndex = 3'h0;
   logic [5:0] valueWrSelect;
   logic [5:0] pwmOut;
   logic faultIrq;
   int mismatches = 0;
   int checksDone = 0;
   logic [7:0] rdQueue [$];
   logic seenRead = 1'b0;
   logic [31:0] lfsr = 32'h4077;
   logic [5:0] mMask = 6'h00;
   logic [5:0] mInv = 6'h00;
   logic [2:0] mSwap = 3'h0;
   logic [2:0] mIndep = 3'h0;
   logic [5:0] selTab [4] = '{6'h01, 6'h3F, 6'h0F, 6'h01};

   // 20 MHz clock
   always #25 clk = ~clk;

   pwmfc_top dut_u (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .waitMode(waitMode),
      .freezeMode(freezeMode), .pwmIn(pwmIn), .faultIn(faultIn),
      .valueWrStrobe(valueWrStrobe), .valueWrIndex(valueWrIndex),
      .valueWrSelect(valueWrSelect), .pwmOut(pwmOut), .faultIrq(faultIrq));

   task automatic cmp(input string what, input logic [7:0] expv, input logic [7:0] seen);
      checksDone++;
      if (seen !== expv)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task automatic summarize();
      if (mismatches == 0 && checksDone > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe, zero otherwise
   always @(posedge clk) seenRead <= regRead;
   always @(negedge clk)
      if (seenRead)
         cmp("regRdData", rdQueue.pop_front(), regRdData);
      else if (reset_n)
         cmp("regRdIdle", 8'h00, regRdData);

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] expv);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      rdQueue.push_back(expv);
      @(posedge clk);
      regRead <= 1'b0;
   endtask

   // Output flop adds one cycle; look half a cycle later to avoid edge races
   task automatic settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic vstrobe(input logic [2:0] idx, input logic [5:0] expv);
      @(posedge clk);
      valueWrStrobe <= 1'b1;
      valueWrIndex <= idx;
      @(posedge clk);
      valueWrStrobe <= 1'b0;
      @(negedge clk);
      cmp("valueWrSelect", {2'b00, expv}, {2'b00, valueWrSelect});
      // The select pulse stands for one cycle only
      @(negedge clk);
      cmp("valueWrSelectIdle", 8'h00, {2'b00, valueWrSelect});
   endtask

   task automatic setFault(input logic v);
      @(posedge clk);
      faultIn <= {3'b000, v};
   endtask

   task automatic modeSet(input int k, input logic v);
      @(posedge clk);
      if (k == 0)
         waitMode <= v;
      else
         freezeMode <= v;
   endtask

   // Bounded wait: a flag that never rises shows up as a mismatch here
   task automatic waitIrq(input int n);
      for (int i = 0; i < n && faultIrq !== 1'b1; i++)
         @(negedge clk);
      cmp("faultIrq", 8'h01, {7'h00, faultIrq});
   endtask

   task automatic setCfg();
      wr(4'h0, {5'h00, mIndep});
      wr(4'h1, {2'b10, mInv});
      wr(4'h2, {2'b00, mMask});
      wr(4'h3, {5'h00, mSwap});
   endtask

   function automatic logic [5:0] expOut(input logic [5:0] raw);
      logic [5:0] s;
      s = raw;
      for (int k = 0; k < 3; k++)
         if (mSwap[k] && !mIndep[k])
         begin
            s[2*k] = raw[2*k+1];
            s[2*k+1] = raw[2*k];
         end
      return (s & ~mMask) ^ mInv;
   endfunction

   function automatic logic [31:0] lfsrNext(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      for (int a = 0; a < 8; a++)
         rd(a[3:0], 8'h00);
      rd(4'hF, 8'h00);
      wr(4'h2, 8'hFF);
      rd(4'h2, 8'h3F);
      wr(4'h3, 8'hFF);
      rd(4'h3, 8'hC0);
      wr(4'h1, 8'h80);
      wr(4'h3, 8'hFF);
      rd(4'h3, 8'hDF);
      for (int m = 0; m < 4; m++)
      begin
         wr(4'h3, {3'b000, m[1:0], 3'b000});
         vstrobe(3'h0, selTab[m]);
      end
      vstrobe(3'h2, 6'h04);
      // Swap in complementary versus independent pairs, then random mixes
      // Mixes put inversion beside masks, so a pair may sit high on both outputs
      for (int i = 0; i < 14; i++)
      begin
         lfsr = lfsrNext(lfsr);
         mMask = (i < 2) ? 6'h00 : lfsr[5:0];
         mInv = (i < 2) ? 6'h00 : lfsr[13:8];
         mSwap = (i < 2) ? 3'h7 : lfsr[18:16];
         mIndep = (i < 2) ? {3{i[0]}} : lfsr[22:20];
         setCfg();
         @(posedge clk);
         pwmIn <= lfsr[29:24];
         settle();
         cmp("pwmOut", {2'b00, expOut(lfsr[29:24])}, {2'b00, pwmOut});
      end
      mMask = 6'h00;
      mInv = 6'h00;
      mSwap = 3'h0;
      mIndep = 3'h0;
      setCfg();
      @(posedge clk);
      pwmIn <= 6'h3F;
      for (int k = 0; k < 2; k++)
      begin
         wr(4'h3, 8'hC0);
         modeSet(k, 1'b1);
         settle();
         cmp("pwmOut", 8'h00, {2'b00, pwmOut});
         modeSet(k, 1'b0);
         settle();
         cmp("pwmOut", 8'h3F, {2'b00, pwmOut});
         wr(4'h3, 8'h00);
         modeSet(k, 1'b1);
         settle();
         cmp("pwmOut", 8'h3F, {2'b00, pwmOut});
         modeSet(k, 1'b0);
      end
      // Manual clearing with interrupt enabled
      wr(4'h8, 8'h01);
      wr(4'h5, 8'h01);
      wr(4'h4, 8'h01);
      setFault(1'b1);
      waitIrq(12);
      cmp("pwmOut", 8'h3E, {2'b00, pwmOut});
      rd(4'h6, 8'h01);
      setFault(1'b0);
      settle();
      cmp("pwmOut", 8'h3E, {2'b00, pwmOut});
      wr(4'h6, 8'h00);
      rd(4'h6, 8'h01);
      wr(4'h6, 8'h01);
      settle();
      cmp("faultIrq", 8'h00, {7'h00, faultIrq});
      cmp("pwmOut", 8'h3F, {2'b00, pwmOut});
      rd(4'h6, 8'h00);
      // Automatic clearing with interrupt disabled
      wr(4'h4, 8'h02);
      setFault(1'b1);
      repeat (10) @(negedge clk);
      cmp("faultIrq", 8'h00, {7'h00, faultIrq});
      setFault(1'b0);
      repeat (12) @(negedge clk);
      cmp("pwmOut", 8'h3F, {2'b00, pwmOut});
      wr(4'h4, 8'h01);
      settle();
      cmp("faultIrq", 8'h01, {7'h00, faultIrq});
      wr(4'h6, 8'h01);
      // Disabled input is ignored
      wr(4'h5, 8'h00);
      setFault(1'b1);
      repeat (10) @(negedge clk);
      cmp("pwmOut", 8'h3F, {2'b00, pwmOut});
      rd(4'h6, 8'h00);
      setFault(1'b0);
      // Five samples needed: three samples in 12 cycles are not enough
      wr(4'h5, 8'h01);
      wr(4'h7, 8'h01);
      setFault(1'b1);
      repeat (12) @(negedge clk);
      cmp("faultIrq", 8'h00, {7'h00, faultIrq});
      waitIrq(20);
      setFault(1'b0);
      wr(4'h6, 8'h01);
      // Write protect is set-only and locks the enable register
      wr(4'h0, 8'h80);
      wr(4'h5, 8'h00);
      rd(4'h5, 8'h01);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h80);
      repeat (2) @(negedge clk);
      summarize();
   end

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial
   begin
      #(50 * 30000);
      mismatches++;
      summarize();
   end
endmodule // tb_top
`default_nettype wire
